// [core/dual_timer_counter.sv]
// Two 16-bit timer/counters with external-interrupt edge flags, AXI4-Lite registers.
// Assumes all pins are synchronous to aclk; irq_ack_* pulses come from the
// interrupt controller when it vectors to the matching external interrupt.
//
// Behaviour
// - Timer operation counts once per machine cycle of 12 clocks.
// - Counter operation counts each falling edge on the unit's count input.
// - Count edge takes two machine cycles to recognise; max rate clock/24.
// - With pin-qualified run set, count only while irq pin high and run set.
// - Counter-select bit 1 picks counter operation, 0 picks timer operation.
// - Two-bit mode field: 13-bit, 16-bit, 8-bit reload, split.
// - Mode 00 counts 13 bits; low byte top three bits held zero.
// - Mode 10 counts low byte; on overflow reloads it from high byte.
// - Timer 1 in mode 11 stops and holds its count.
// - Timer 0 in mode 11 acts as two independent 8-bit units.
// - Split high byte runs on timer 1 run bit, sets timer 1 overflow.
// - Overflow sets the unit's overflow flag; software clears it.
// - Clearing a unit's run bit stops it.
// - Falling edge on irq pin sets edge flag; interrupt service clears it.
// - Type bit picks falling edge or low level as interrupt request.
// - In level mode the flag follows the inverted pin level, set while the pin is low.
//
// Added by the designer: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
module dual_timer_counter #(
  parameter int ADDR_W = 8
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic count_input_a,
  input wire logic count_input_b,
  input wire logic ext_irq_pin_a,
  input wire logic ext_irq_pin_b,
  input wire logic irq_ack_a,
  input wire logic irq_ack_b,
  output logic timer0_overflow_flag,
  output logic timer1_overflow_flag,
  output logic ext_irq_a_flag,
  output logic ext_irq_b_flag
);

  logic tick;
  logic [3:0] pin_level;
  logic [3:0] pin_fall;
  logic [7:0] mode_q;
  logic [7:0] flags_q;
  logic [7:0] t0_low_q;
  logic [7:0] t0_high_q;
  logic [7:0] t1_low_q;
  logic [7:0] t1_high_q;
  logic wr_fire;
  logic rd_fire;
  logic wr_ok;
  logic [7:0] wr_byte;
  logic [7:0] rd_val;
  logic rd_ok;
  timer_pkg::count_s step0;
  timer_pkg::count_s step1;
  logic [3:0] cfg0;
  logic [3:0] cfg1;
  logic en0;
  logic en1;
  logic inc0;
  logic inc1;
  logic split0;
  logic inc0_high;
  logic [8:0] split_high;
  logic set_t0_ovf;
  logic set_t1_ovf;

  mc_tick_gen #(
    .PERIOD(timer_pkg::CLKS_PER_MC)
  ) u_tick (
    .aclk(aclk),
    .aresetn(aresetn),
    .tick(tick)
  );

  // Pin order: count a, count b, irq a, irq b
  logic [3:0] pins;
  assign pins = {ext_irq_pin_b, ext_irq_pin_a, count_input_b, count_input_a};

  for (genvar i = 0; i < 4; i++)
  begin : g_pin
    pin_sampler u_samp (
      .aclk(aclk),
      .aresetn(aresetn),
      .tick(tick),
      .pin(pins[i]),
      .level(pin_level[i]),
      .fall(pin_fall[i])
    );
  end

  // One counting step of a unit for its mode
  function automatic timer_pkg::count_s count_step(
    input timer_pkg::mode_e mode,
    input logic [7:0] low,
    input logic [7:0] high,
    input logic inc
  );
    timer_pkg::count_s r;
    logic [13:0] s13;
    logic [16:0] s16;
    r.low = low;
    r.high = high;
    r.ovf = 1'b0;
    s13 = {1'b0, high, low[4:0]} + 14'h0001;
    s16 = {1'b0, high, low} + 17'h00001;
    unique case (mode)
      timer_pkg::MODE_13BIT:
      begin
        r.low = {3'h0, low[4:0]};
        if (inc)
        begin
          r.low = {3'h0, s13[4:0]};
          r.high = s13[12:5];
          r.ovf = s13[13];
        end
      end
      timer_pkg::MODE_16BIT:
      begin
        if (inc)
        begin
          r.low = s16[7:0];
          r.high = s16[15:8];
          r.ovf = s16[16];
        end
      end
      timer_pkg::MODE_RELOAD8:
      begin
        if (inc)
        begin
          r.ovf = (low == 8'hFF);
          r.low = r.ovf ? high : low + 8'h01;
        end
      end
      timer_pkg::MODE_SPLIT:
      begin
        if (inc)
        begin
          r.ovf = (low == 8'hFF);
          r.low = low + 8'h01;
        end
      end
    endcase
    return r;
  endfunction : count_step

  assign cfg1 = mode_q[timer_pkg::MC_T1_NIBBLE +: 4];
  assign cfg0 = mode_q[timer_pkg::MC_T0_NIBBLE +: 4];

  // Run bit gates counting; gate bit adds the irq pin level
  assign en0 = flags_q[timer_pkg::RF_T0_RUN]
    & (~cfg0[timer_pkg::MC_GATE] | pin_level[2]);
  assign en1 = flags_q[timer_pkg::RF_T1_RUN]
    & (~cfg1[timer_pkg::MC_GATE] | pin_level[3]);

  assign inc0 = en0 & (cfg0[timer_pkg::MC_COUNTER_SEL] ? pin_fall[0] : tick);
  assign split0 = (timer_pkg::mode_e'(cfg0[1:0]) == timer_pkg::MODE_SPLIT);
  // Timer 1 in split mode holds, so its step gets no increment
  assign inc1 = en1 & (timer_pkg::mode_e'(cfg1[1:0]) != timer_pkg::MODE_SPLIT)
    & (cfg1[timer_pkg::MC_COUNTER_SEL] ? pin_fall[1] : tick);

  assign step0 = count_step(timer_pkg::mode_e'(cfg0[1:0]), t0_low_q, t0_high_q, inc0);
  assign step1 = count_step(timer_pkg::mode_e'(cfg1[1:0]), t1_low_q, t1_high_q, inc1);

  // Split high byte is a plain machine-cycle timer run by timer 1's run bit
  assign inc0_high = split0 & tick & flags_q[timer_pkg::RF_T1_RUN];
  assign split_high = {1'b0, t0_high_q} + 9'h001;

  assign set_t0_ovf = step0.ovf;
  // While timer 0 is split its high byte owns timer 1's flag
  assign set_t1_ovf = split0 ? (inc0_high & split_high[8]) : step1.ovf;

  // Bus decode
  assign wr_fire = s_axi_awready;
  assign rd_fire = s_axi_arready;
  assign wr_byte = s_axi_wdata[7:0];

  always_comb
  begin
    wr_ok = 1'b1;
    unique case (s_axi_awaddr[7:0])
      timer_pkg::ADDR_MODE_CONTROL,
      timer_pkg::ADDR_RUN_AND_FLAGS,
      timer_pkg::ADDR_TIMER0_LOW,
      timer_pkg::ADDR_TIMER0_HIGH,
      timer_pkg::ADDR_TIMER1_LOW,
      timer_pkg::ADDR_TIMER1_HIGH: wr_ok = 1'b1;
      default: wr_ok = 1'b0;
    endcase
  end

  always_comb
  begin
    rd_val = 8'h00;
    rd_ok = 1'b1;
    unique case (s_axi_araddr[7:0])
      timer_pkg::ADDR_MODE_CONTROL: rd_val = mode_q;
      timer_pkg::ADDR_RUN_AND_FLAGS: rd_val = flags_q;
      timer_pkg::ADDR_TIMER0_LOW: rd_val = t0_low_q;
      timer_pkg::ADDR_TIMER0_HIGH: rd_val = t0_high_q;
      timer_pkg::ADDR_TIMER1_LOW: rd_val = t1_low_q;
      timer_pkg::ADDR_TIMER1_HIGH: rd_val = t1_high_q;
      default: rd_ok = 1'b0;
    endcase
  end

  function automatic logic wr_hit(input logic [7:0] addr);
    return wr_fire & s_axi_wstrb[0] & (s_axi_awaddr[7:0] == addr);
  endfunction : wr_hit

  // Write channel: waits for address and data together, one write at a time
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= timer_pkg::RESP_OKAY;
    end
    else
    begin
      s_axi_awready <= s_axi_awvalid & s_axi_wvalid & ~s_axi_awready & ~s_axi_bvalid;
      s_axi_wready <= s_axi_awvalid & s_axi_wvalid & ~s_axi_awready & ~s_axi_bvalid;
      if (wr_fire)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_ok ? timer_pkg::RESP_OKAY : timer_pkg::RESP_SLVERR;
      end
      else if (s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  // Read channel
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= timer_pkg::RESP_OKAY;
    end
    else
    begin
      s_axi_arready <= s_axi_arvalid & ~s_axi_arready & ~s_axi_rvalid;
      if (rd_fire)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= {24'h000000, rd_val};
        s_axi_rresp <= rd_ok ? timer_pkg::RESP_OKAY : timer_pkg::RESP_SLVERR;
      end
      else if (s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      mode_q <= timer_pkg::RST_MODE_CONTROL;
    else if (wr_hit(timer_pkg::ADDR_MODE_CONTROL))
      mode_q <= wr_byte;
  end

  // Count bytes: a software write to a byte wins over counting of that byte
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      t0_low_q <= timer_pkg::RST_COUNT;
      t0_high_q <= timer_pkg::RST_COUNT;
      t1_low_q <= timer_pkg::RST_COUNT;
      t1_high_q <= timer_pkg::RST_COUNT;
    end
    else
    begin
      t0_low_q <= wr_hit(timer_pkg::ADDR_TIMER0_LOW) ? wr_byte : step0.low;
      if (wr_hit(timer_pkg::ADDR_TIMER0_HIGH))
        t0_high_q <= wr_byte;
      else if (split0)
        t0_high_q <= inc0_high ? split_high[7:0] : t0_high_q;
      else
        t0_high_q <= step0.high;
      t1_low_q <= wr_hit(timer_pkg::ADDR_TIMER1_LOW) ? wr_byte : step1.low;
      t1_high_q <= wr_hit(timer_pkg::ADDR_TIMER1_HIGH) ? wr_byte : step1.high;
    end
  end

  // Sticky flags: hardware set wins over a software or acknowledge clear
  logic wr_flags;
  assign wr_flags = wr_hit(timer_pkg::ADDR_RUN_AND_FLAGS);

  function automatic logic sticky(
    input logic cur,
    input logic set,
    input logic clr,
    input logic wr,
    input logic wv
  );
    if (set)
      return 1'b1;
    if (wr)
      return wv;
    return cur & ~clr;
  endfunction : sticky

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      flags_q <= timer_pkg::RST_RUN_AND_FLAGS;
    else
    begin
      flags_q[timer_pkg::RF_T1_OVF] <= sticky(flags_q[timer_pkg::RF_T1_OVF], set_t1_ovf,
        1'b0, wr_flags, wr_byte[timer_pkg::RF_T1_OVF]);
      flags_q[timer_pkg::RF_T0_OVF] <= sticky(flags_q[timer_pkg::RF_T0_OVF], set_t0_ovf,
        1'b0, wr_flags, wr_byte[timer_pkg::RF_T0_OVF]);
      if (wr_flags)
      begin
        flags_q[timer_pkg::RF_T1_RUN] <= wr_byte[timer_pkg::RF_T1_RUN];
        flags_q[timer_pkg::RF_T0_RUN] <= wr_byte[timer_pkg::RF_T0_RUN];
        flags_q[timer_pkg::RF_IRQ_B_TYPE] <= wr_byte[timer_pkg::RF_IRQ_B_TYPE];
        flags_q[timer_pkg::RF_IRQ_A_TYPE] <= wr_byte[timer_pkg::RF_IRQ_A_TYPE];
      end
      // Type 1 latches falling edges, type 0 mirrors a low pin
      if (flags_q[timer_pkg::RF_IRQ_B_TYPE])
        flags_q[timer_pkg::RF_IRQ_B_FLAG] <= sticky(flags_q[timer_pkg::RF_IRQ_B_FLAG],
          pin_fall[3], irq_ack_b, wr_flags, wr_byte[timer_pkg::RF_IRQ_B_FLAG]);
      else
        flags_q[timer_pkg::RF_IRQ_B_FLAG] <= ~pin_level[3];
      if (flags_q[timer_pkg::RF_IRQ_A_TYPE])
        flags_q[timer_pkg::RF_IRQ_A_FLAG] <= sticky(flags_q[timer_pkg::RF_IRQ_A_FLAG],
          pin_fall[2], irq_ack_a, wr_flags, wr_byte[timer_pkg::RF_IRQ_A_FLAG]);
      else
        flags_q[timer_pkg::RF_IRQ_A_FLAG] <= ~pin_level[2];
    end
  end

  // Flag outputs mirror the register one cycle later so they leave a flip-flop
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      timer0_overflow_flag <= 1'b0;
      timer1_overflow_flag <= 1'b0;
      ext_irq_a_flag <= 1'b0;
      ext_irq_b_flag <= 1'b0;
    end
    else
    begin
      timer0_overflow_flag <= flags_q[timer_pkg::RF_T0_OVF];
      timer1_overflow_flag <= flags_q[timer_pkg::RF_T1_OVF];
      ext_irq_a_flag <= flags_q[timer_pkg::RF_IRQ_A_FLAG];
      ext_irq_b_flag <= flags_q[timer_pkg::RF_IRQ_B_FLAG];
    end
  end

endmodule : dual_timer_counter
`default_nettype wire

// [core/timer_pkg.sv]
// Shared constants and types for the dual timer/counter block.
// Assumes a single 100 MHz core clock and a 32-bit AXI4-Lite register bus.
package timer_pkg;

  // Core clock period and machine cycle length
  localparam int CLK_PERIOD_NS = 10;
  localparam int CLKS_PER_MC = 12;

  // Register byte addresses
  localparam logic [7:0] ADDR_MODE_CONTROL = 8'h00;
  localparam logic [7:0] ADDR_RUN_AND_FLAGS = 8'h04;
  localparam logic [7:0] ADDR_TIMER0_LOW = 8'h08;
  localparam logic [7:0] ADDR_TIMER0_HIGH = 8'h0C;
  localparam logic [7:0] ADDR_TIMER1_LOW = 8'h10;
  localparam logic [7:0] ADDR_TIMER1_HIGH = 8'h14;

  // Mode control fields: upper nibble timer 1, lower nibble timer 0
  localparam int MC_T1_NIBBLE = 4;
  localparam int MC_T0_NIBBLE = 0;
  localparam int MC_GATE = 3;
  localparam int MC_COUNTER_SEL = 2;
  localparam int MC_MODE_HI = 1;
  localparam int MC_MODE_LO = 0;

  // Run and flags fields
  localparam int RF_T1_OVF = 7;
  localparam int RF_T1_RUN = 6;
  localparam int RF_T0_OVF = 5;
  localparam int RF_T0_RUN = 4;
  localparam int RF_IRQ_B_FLAG = 3;
  localparam int RF_IRQ_B_TYPE = 2;
  localparam int RF_IRQ_A_FLAG = 1;
  localparam int RF_IRQ_A_TYPE = 0;

  // Reset values
  localparam logic [7:0] RST_MODE_CONTROL = 8'h00;
  localparam logic [7:0] RST_RUN_AND_FLAGS = 8'h00;
  localparam logic [7:0] RST_COUNT = 8'h00;

  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    MODE_13BIT = 2'h0,
    MODE_16BIT = 2'h1,
    MODE_RELOAD8 = 2'h2,
    MODE_SPLIT = 2'h3
  } mode_e;

  // One unit's count bytes and the overflow produced by a step
  typedef struct packed {
    logic [7:0] low;
    logic [7:0] high;
    logic ovf;
  } count_s;

endpackage : timer_pkg

// [core/mc_tick_gen.sv]
// Machine cycle tick: one pulse every CLKS_PER_MC core clocks.
// Assumes a free-running core clock and a synchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none
module mc_tick_gen #(
  parameter int PERIOD = timer_pkg::CLKS_PER_MC
) (
  input wire logic aclk,
  input wire logic aresetn,
  output logic tick
);
  logic [$clog2(PERIOD)-1:0] cnt_q;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      cnt_q <= '0;
      tick <= 1'b0;
    end
    else
    begin
      tick <= (cnt_q == $clog2(PERIOD)'(PERIOD - 1));
      if (cnt_q == $clog2(PERIOD)'(PERIOD - 1))
        cnt_q <= '0;
      else
        cnt_q <= cnt_q + 1'b1;
    end
  end
endmodule : mc_tick_gen
`default_nettype wire

// [core/pin_sampler.sv]
// Samples one input pin once per machine cycle and reports falling edges.
// Assumes the pin is synchronous to the core clock.
`timescale 1ns/1ps
`default_nettype none
module pin_sampler (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic tick,
  input wire logic pin,
  output logic level,
  output logic fall
);
  logic cur_q;
  logic prev_q;

  // A low seen at one tick is reported at the next, two machine cycles in all
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      cur_q <= 1'b1;
      prev_q <= 1'b1;
    end
    else if (tick)
    begin
      cur_q <= pin;
      prev_q <= cur_q;
    end
  end

  assign level = cur_q;
  assign fall = tick & prev_q & ~cur_q;
endmodule : pin_sampler
`default_nettype wire

// [tb/dual_timer_counter_props.sv]
// Checker for the register bus handshakes of the dual timer/counter.
// Sees only the top module's ports; bound into every instance at the foot.
`timescale 1ns/1ps
`default_nettype none
module dual_timer_counter_props (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  // Offer seen while nothing is pending and not yet taken
  sequence wr_offer;
    s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid && !s_axi_awready;
  endsequence
  sequence wr_taken;
    s_axi_awready && s_axi_wready;
  endsequence
  chk_wr_accept: assert property (wr_offer |=> wr_taken)
    else $error("write offer not taken");
  chk_wr_pair: assert property (s_axi_awready |-> s_axi_wready && !s_axi_bvalid)
    else $error("address and data not taken together");
  chk_b_follows: assert property (wr_taken |=> s_axi_bvalid)
    else $error("write response late");
  chk_b_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response not held");
  chk_b_release: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response not released");
  chk_rd_accept: assert property (s_axi_arvalid && !s_axi_rvalid && !s_axi_arready |=> s_axi_arready)
    else $error("read offer not taken");
  chk_r_follows: assert property (s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");
  chk_r_holds: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data not held");
  chk_rdata_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
    else $error("read data upper bits set");
endmodule : dual_timer_counter_props

bind dual_timer_counter dual_timer_counter_props i_props (
  .aclk(aclk),
  .aresetn(aresetn),
  .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready),
  .s_axi_bresp(s_axi_bresp),
  .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready),
  .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata),
  .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready)
);
`default_nettype wire

// [tb/timer_pin_model.sv]
// Model of the pins around the timer block: two count inputs, two irq pins.
// Levels change just after a rising edge; the bench calls the tasks in turn.
`timescale 1ns/1ps
`default_nettype none
module timer_pin_model (
  input wire logic aclk,
  output var logic [3:0] pins
);
  // Bits: 0 count a, 1 count b, 2 irq a, 3 irq b; all idle high
  initial pins = 4'hF;
  task automatic set_lvl(input int k, input logic v);
    @(posedge aclk);
    pins[k] <= v;
  endtask : set_lvl
  // Shorter levels could fall between two samples and be lost
  task automatic pulses(input int k, input int n, input int half);
    if (half < 12)
      half = 12;
    repeat (n)
    begin
      set_lvl(k, 1'b0);
      repeat (half - 1) @(posedge aclk);
      set_lvl(k, 1'b1);
      repeat (half - 1) @(posedge aclk);
    end
  endtask : pulses
endmodule : timer_pin_model
`default_nettype wire

// [tb/dual_timer_counter_tb_top.sv]
// Self-checking bench: register table, timing, modes and irq flags.
// Assumes the pin model and the bound checker are compiled before it.
`timescale 1ns/1ps
`default_nettype none
module dual_timer_counter_tb_top;
  typedef struct packed {
    logic [7:0] a;
    logic [31:0] d;
    logic [31:0] e;
    logic [1:0] r;
  } row_s;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h00000000;
  logic [3:0] wstrb = 4'h0;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic irq_ack_a = 1'b0;
  logic irq_ack_b = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp, rs;
  logic [31:0] rdata, rdat, keep;
  logic [3:0] pins, flg;
  int n_errors = 0;
  int comparisons = 0;
  int cyc = 0;
  int t0;
  row_s rows [6] = '{
    '{8'h00, 32'h00000011, 32'h00000011, 2'h0},
    '{8'h08, 32'h000000AB, 32'h000000AB, 2'h0},
    '{8'h0C, 32'h000000CD, 32'h000000CD, 2'h0},
    '{8'h10, 32'h000001FF, 32'h000000FF, 2'h0},
    '{8'h14, 32'h00000034, 32'h00000034, 2'h0},
    '{8'h18, 32'h00000077, 32'h00000000, 2'h2}};

  always #5 aclk = ~aclk;
  always @(posedge aclk) cyc <= cyc + 1;

  timer_pin_model i_pins (.aclk(aclk), .pins(pins));
  dual_timer_counter i_dut (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .count_input_a(pins[0]), .count_input_b(pins[1]),
    .ext_irq_pin_a(pins[2]), .ext_irq_pin_b(pins[3]),
    .irq_ack_a(irq_ack_a), .irq_ack_b(irq_ack_b),
    .timer0_overflow_flag(flg[0]), .timer1_overflow_flag(flg[1]),
    .ext_irq_a_flag(flg[2]), .ext_irq_b_flag(flg[3]));

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic print_verdict();
    $display("Counts: %0d comparisons, %0d mismatches", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : print_verdict
  task automatic timed_out(input int i);
    if (i >= 50)
    begin
      n_errors++;
      $display("Error wait ran out");
      print_verdict();
    end
  endtask : timed_out
  // Ready is raised only after valid is seen, so the hold phase is exercised
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    int i;
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hF;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    for (i = 0; i < 50; i++)
    begin
      @(posedge aclk);
      if (awready === 1'b1)
        break;
    end
    timed_out(i);
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    for (i = 0; i < 50 && bvalid !== 1'b1; i++) @(posedge aclk);
    timed_out(i);
    bready <= 1'b1;
    @(posedge aclk);
    rs = bresp;
    bready <= 1'b0;
  endtask : wr_reg
  task automatic rd_reg(input logic [7:0] a);
    int i;
    araddr <= a;
    arvalid <= 1'b1;
    for (i = 0; i < 50; i++)
    begin
      @(posedge aclk);
      if (arready === 1'b1)
        break;
    end
    timed_out(i);
    arvalid <= 1'b0;
    for (i = 0; i < 50 && rvalid !== 1'b1; i++) @(posedge aclk);
    timed_out(i);
    rready <= 1'b1;
    @(posedge aclk);
    rdat = rdata;
    rs = rresp;
    rready <= 1'b0;
  endtask : rd_reg
  task automatic wait_flag(input int k, input logic v);
    int i;
    for (i = 0; i < 50 && flg[k] !== v; i++) @(posedge aclk);
    timed_out(i);
  endtask : wait_flag

  initial
  begin
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    check("flags after reset", flg, 4'h0);
    for (int k = 0; k < 24; k += 4)
    begin
      rd_reg(8'(k));
      check("reset value", rdat, 32'h00000000);
    end
    foreach (rows[k])
    begin
      wr_reg(rows[k].a, rows[k].d);
      check("bresp", rs, rows[k].r);
      rd_reg(rows[k].a);
      check("rdata", rdat, rows[k].e);
      check("rresp", rs, rows[k].r);
    end
    $display("Done: register table");
    wr_reg(8'h00, 32'h00000002);
    wr_reg(8'h0C, 32'h000000FE);
    wr_reg(8'h08, 32'h000000FE);
    wr_reg(8'h04, 32'h00000010);
    wait_flag(0, 1'b1);
    t0 = cyc;
    wr_reg(8'h04, 32'h00000010);
    check("overflow cleared", flg[0], 1'b0);
    wait_flag(0, 1'b1);
    check("reload period", cyc - t0, 32'h00000018);
    wr_reg(8'h04, 32'h00000000);
    rd_reg(8'h08);
    keep = rdat;
    repeat (30) @(posedge aclk);
    rd_reg(8'h08);
    check("stopped count", rdat, keep);
    $display("Done: timer reload and stop");
    wr_reg(8'h00, 32'h00000005);
    wr_reg(8'h08, 32'h00000000);
    wr_reg(8'h04, 32'h00000010);
    i_pins.pulses(0, 3, 12);
    repeat (24) @(posedge aclk);
    rd_reg(8'h08);
    check("edge count", rdat, 32'h00000003);
    wr_reg(8'h00, 32'h0000000D);
    wr_reg(8'h08, 32'h00000000);
    i_pins.set_lvl(2, 1'b0);
    i_pins.pulses(0, 2, 12);
    i_pins.set_lvl(2, 1'b1);
    repeat (12) @(posedge aclk);
    i_pins.pulses(0, 1, 12);
    repeat (24) @(posedge aclk);
    rd_reg(8'h08);
    check("gated count", rdat, 32'h00000001);
    $display("Done: counter and gate");
    wr_reg(8'h04, 32'h00000000);
    wr_reg(8'h00, 32'h00000033);
    wr_reg(8'h08, 32'h00000055);
    wr_reg(8'h0C, 32'h000000FF);
    wr_reg(8'h10, 32'h00000066);
    wr_reg(8'h04, 32'h00000040);
    wait_flag(1, 1'b1);
    rd_reg(8'h08);
    check("split low byte", rdat, 32'h00000055);
    rd_reg(8'h10);
    check("timer 1 held", rdat, 32'h00000066);
    $display("Done: split mode");
    wr_reg(8'h04, 32'h00000001);
    i_pins.pulses(2, 1, 24);
    check("edge flag latched", flg[2], 1'b1);
    irq_ack_a <= 1'b1;
    @(posedge aclk);
    irq_ack_a <= 1'b0;
    repeat (3) @(posedge aclk);
    check("edge flag acked", flg[2], 1'b0);
    i_pins.set_lvl(3, 1'b0);
    wait_flag(3, 1'b1);
    irq_ack_b <= 1'b1;
    @(posedge aclk);
    irq_ack_b <= 1'b0;
    repeat (3) @(posedge aclk);
    check("level flag kept", flg[3], 1'b1);
    i_pins.set_lvl(3, 1'b1);
    wait_flag(3, 1'b0);
    $display("Done: irq flags");
    // Timer 1 as a 13-bit counter on its own pin, two edges from the top wrap it
    wr_reg(8'h00, 32'h00000040);
    wr_reg(8'h10, 32'h000000FE);
    rd_reg(8'h10);
    check("13-bit low byte", rdat, 32'h0000001E);
    wr_reg(8'h14, 32'h000000FF);
    wr_reg(8'h04, 32'h00000040);
    i_pins.pulses(1, 2, 12);
    repeat (24) @(posedge aclk);
    rd_reg(8'h14);
    check("13-bit wrap", rdat, 32'h00000000);
    check("timer 1 overflow", flg[1], 1'b1);
    $display("Done: 13-bit counter b");
    // A second reset with run bit, flag and mode set must clear them all
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    check("flags after mid reset", flg, 4'h0);
    rd_reg(8'h04);
    check("run bits after reset", rdat, 32'h00000000);
    rd_reg(8'h00);
    check("mode after reset", rdat, 32'h00000000);
    $display("Done: mid-run reset");
    print_verdict();
  end

  initial
  begin
    repeat (100000) @(posedge aclk);
    n_errors++;
    $display("Error run limit reached");
    print_verdict();
  end
endmodule : dual_timer_counter_tb_top
`default_nettype wire
